// File: pkg/astc_pkg.sv
// Purpose: Shared constants and types for acquisition sequence and trigger control
// Assumes: 250 MHz system clock
// Notes:   All timing counts derive from printed figures and the clock period
package astc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS     = 4000;          // System clock period
  localparam int unsigned HOLDOFF_MIN_NS    = 10;            // Shortest time hold-off
  localparam int unsigned HOLDOFF_MIN_CYC   = (HOLDOFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned HOLDOFF_MAX_S = 20;            // Longest time hold-off
  localparam longint unsigned HOLDOFF_MAX_CYC = (HOLDOFF_MAX_S * 64'd1000000000000) / CLK_PERIOD_PS;
  localparam int unsigned EVT_MAX           = 1000000000;    // Largest event hold-off count
  localparam int unsigned EXT_PRESENT_PULSES = 50;           // Pulses before external clock is seen
  localparam int unsigned SEG_DIVS          = 10;            // Segment spans ten divisions

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned HO_W   = 33;                       // Hold-off time counter width
  localparam int unsigned EV_W   = 30;                       // Event counter width
  localparam int unsigned SEG_W  = 16;                       // Segment index width
  localparam int unsigned DIV_W  = 24;                       // Per-division count width
  localparam int unsigned LVL_W  = 12;                       // Trigger level code width
  localparam int unsigned NSRC   = 7;                        // Trigger sources
  localparam int unsigned SRC_W  = 3;                        // Source select width
  localparam int unsigned PRES_W = 6;                        // Presence counter width

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SRC_CH1   = 3'h0,
    SRC_CH2   = 3'h1,
    SRC_CH3   = 3'h2,
    SRC_CH4   = 3'h3,
    SRC_LINE  = 3'h4,
    SRC_EXT   = 3'h5,
    SRC_EXT10 = 3'h6
  } astc_src_e;

  typedef enum logic [1:0]
  {
    TM_AUTO = 2'h0,
    TM_REARM = 2'h1,
    TM_ONE_SHOT = 2'h2
  } astc_tmode_e;

  typedef enum logic [1:0]
  {
    SEQ_OFF  = 2'h0,
    SEQ_ON   = 2'h1,
    SEQ_WRAP = 2'h2
  } astc_seq_e;

  typedef enum logic [2:0]
  {
    CPL_DC     = 3'h0,
    CPL_AC     = 3'h1,
    CPL_LOW_FREQ_REJECT_COUPLING = 3'h2,
    CPL_HIGH_FREQ_REJECT_COUPLING = 3'h3,
    CPL_HF     = 3'h4
  } astc_cpl_e;

  typedef enum logic [1:0]
  {
    CHU_1 = 2'h0,
    CHU_2 = 2'h1,
    CHU_4 = 2'h2
  } astc_chuse_e;

  localparam logic [1:0] SAMP_SINGLE = 2'h0;                 // Single-shot sampling
  localparam logic [1:0] SAMP_RIS    = 2'h1;                 // Random interleaved sampling

  // Per-source trigger settings
  typedef struct packed
  {
    logic [LVL_W-1:0] level;
    astc_cpl_e        coupling;
    logic             slope_neg;
  } astc_trig_cfg_s;

  localparam astc_trig_cfg_s TRIG_CFG_RST = '{level: 12'h800, coupling: CPL_DC, slope_neg: 1'b0};

endpackage

// File: verilog/astc_sync3.sv
// Purpose: Three-stage synchroniser with agreement check for a pin input
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second; a change counts when stages two and three agree
`timescale 1ns/1ps
module astc_sync3
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout,
  output logic      rise
);

  logic [2:0] stg_q;    // Synchroniser chain
  logic [2:0] stg_d;
  logic       out_q;    // Agreed level
  logic       out_d;

  // Next stage values and agreed level
  always_comb
  begin
    stg_d = {stg_q[1:0], din};
    out_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : out_q;
  end

  // Register chain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stg_q <= 3'h0;
      out_q <= 1'b0;
    end
    else
    begin
      stg_q <= stg_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
  assign rise = out_d & ~out_q;

endmodule

// File: verilog/astc_ctrl.sv
// Purpose: Acquisition sequence and edge trigger control
// Assumes: Operator controls are synchronous; comparators and sample clock are pins
// Notes:   Segment timing counted in clk cycles or external samples; time hold-off always in clk cycles
`timescale 1ns/1ps
module astc_ctrl
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Operator controls
  input  wire logic                     arm,
  input  wire logic                     stop_cmd,
  input  wire astc_pkg::astc_tmode_e    trig_mode,
  input  wire astc_pkg::astc_seq_e      seq_mode,
  input  wire logic [astc_pkg::SEG_W-1:0] seg_count,
  input  wire logic [astc_pkg::DIV_W-1:0] per_div,
  input  wire logic                     per_div_wr,
  input  wire logic                     ext_clk_req,
  input  wire logic [1:0]               samp_mode_req,
  input  wire astc_pkg::astc_chuse_e    ch_use,
  input  wire logic                     four_ch_unit,
  input  wire logic [31:0]              auto_timeout,
  input  wire astc_pkg::astc_src_e      trig_src,
  input  wire logic                     cfg_wr,
  input  wire astc_pkg::astc_trig_cfg_s cfg_wdata,
  input  wire logic                     smart_type,
  input  wire logic                     holdoff_by_evt,
  input  wire logic [astc_pkg::HO_W-1:0] holdoff_time,
  input  wire logic [astc_pkg::EV_W-1:0] holdoff_evts,
  // Pins
  input  wire logic                     rear_sample_clock_input,
  input  wire logic [astc_pkg::NSRC-1:0] cmp_pos,
  // Outputs
  output logic                          adc_sample_en,
  output logic                          ext_clk_active,
  output logic                          ext_clk_present,
  output logic [1:0]                    samp_mode,
  output logic [1:0]                    pair_mask,
  output logic                          stamp_en,
  output astc_pkg::astc_trig_cfg_s      cur_cfg,
  output logic                          nv_wr,
  output logic [astc_pkg::SRC_W-1:0]    nv_addr,
  output astc_pkg::astc_trig_cfg_s      nv_wdata,
  output logic                          trig_out,
  output logic [astc_pkg::SEG_W-1:0]    seg_idx,
  output logic                          acq_busy,
  output logic                          done
);

  // ----------------------------------------------------------------
  // Sample clock pin and presence
  // ----------------------------------------------------------------
  logic ext_lvl;       // Synchronised external clock level
  logic ext_rise;      // Rising edge pulse

  astc_sync3 u_ext_sync
  (
    .clk  (clk),
    .rst  (rst),
    .din  (rear_sample_clock_input),
    .dout (ext_lvl),
    .rise (ext_rise)
  );

  logic                       ext_sel_q, ext_sel_d;    // External clock selected
  logic [astc_pkg::PRES_W-1:0] pres_q, pres_d;         // Pulse count toward presence
  logic                       pres_ok_q, pres_ok_d;    // External clock recognised
  logic                       ext_blk_q, ext_blk_d;    // Held internal after a scale change

  // Selection, presence counting
  always_comb
  begin
    ext_sel_d = ext_sel_q;
    ext_blk_d = ext_blk_q;
    pres_d    = pres_q;
    pres_ok_d = pres_ok_q;
    if (ext_clk_req && trig_src != astc_pkg::SRC_EXT && trig_src != astc_pkg::SRC_EXT10)
      ext_sel_d = 1'b1;
    if (!ext_clk_req || trig_src == astc_pkg::SRC_EXT || trig_src == astc_pkg::SRC_EXT10)
      ext_sel_d = 1'b0;
    // Scale change drops to internal clock and stays there until the request is withdrawn
    if (!ext_clk_req)
      ext_blk_d = 1'b0;
    if (per_div_wr)
      ext_blk_d = 1'b1;
    if (per_div_wr || ext_blk_q)
      ext_sel_d = 1'b0;
    if (!ext_sel_q)
    begin
      pres_d    = '0;
      pres_ok_d = 1'b0;
    end
    else if (ext_rise && !pres_ok_q)
    begin
      if (pres_q == astc_pkg::PRES_W'(astc_pkg::EXT_PRESENT_PULSES - 1))
        pres_ok_d = 1'b1;
      pres_d = pres_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_sel_q <= 1'b0;
      pres_q    <= '0;
      pres_ok_q <= 1'b0;
      ext_blk_q <= 1'b0;
    end
    else
    begin
      ext_sel_q <= ext_sel_d;
      pres_q    <= pres_d;
      pres_ok_q <= pres_ok_d;
      ext_blk_q <= ext_blk_d;
    end
  end

  assign ext_clk_active  = ext_sel_q;
  assign ext_clk_present = pres_ok_q;
  // Sample tick: external rising edge once the clock is recognised, or every internal cycle
  logic tick;
  assign tick = ext_sel_q ? (ext_rise & pres_ok_q) : 1'b1;
  assign adc_sample_en = tick;
  assign samp_mode = ext_sel_q ? astc_pkg::SAMP_SINGLE : samp_mode_req;
  assign stamp_en  = ~ext_sel_q;
  // Pairs: bit0 = 1 with 2 (or both on two-channel), bit1 = 3 with 4
  assign pair_mask = (ch_use == astc_pkg::CHU_2) ? {four_ch_unit, 1'b1} : 2'h0;

  // ----------------------------------------------------------------
  // Per-source trigger settings
  // ----------------------------------------------------------------
  astc_pkg::astc_trig_cfg_s cfg_q [astc_pkg::NSRC];   // Settings per source
  astc_pkg::astc_trig_cfg_s cfg_d [astc_pkg::NSRC];
  logic                     nvw_q, nvw_d;              // Store write strobe
  logic [astc_pkg::SRC_W-1:0] nva_q, nva_d;
  astc_pkg::astc_trig_cfg_s nvd_q, nvd_d;

  genvar gi;
  generate
    for (gi = 0; gi < astc_pkg::NSRC; gi++)
    begin : g_cfg
      // Write only the selected source's slot
      always_comb
      begin
        cfg_d[gi] = cfg_q[gi];
        if (cfg_wr && trig_src == astc_pkg::astc_src_e'(gi))
          cfg_d[gi] = cfg_wdata;
      end
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          cfg_q[gi] <= astc_pkg::TRIG_CFG_RST;
        else
          cfg_q[gi] <= cfg_d[gi];
      end
    end
  endgenerate

  // Mirror every change to non-volatile store
  always_comb
  begin
    nvw_d = cfg_wr;
    nva_d = cfg_wr ? trig_src : nva_q;
    nvd_d = cfg_wr ? cfg_wdata : nvd_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvw_q <= 1'b0;
      nva_q <= '0;
      nvd_q <= astc_pkg::TRIG_CFG_RST;
    end
    else
    begin
      nvw_q <= nvw_d;
      nva_q <= nva_d;
      nvd_q <= nvd_d;
    end
  end

  assign nv_wr    = nvw_q;
  assign nv_addr  = nva_q;
  assign nv_wdata = nvd_q;

  // Effective settings: high-freq becomes AC on conflict
  astc_pkg::astc_trig_cfg_s eff;
  always_comb
  begin
    eff = cfg_q[trig_src];
    if (eff.coupling == astc_pkg::CPL_HF && (smart_type || holdoff_by_evt))
      eff.coupling = astc_pkg::CPL_AC;
    if (eff.coupling == astc_pkg::CPL_HF)
      eff.slope_neg = 1'b0;
  end
  assign cur_cfg = eff;

  // ----------------------------------------------------------------
  // Comparator qualification and hold-off
  // ----------------------------------------------------------------
  logic [astc_pkg::NSRC-1:0] cmp_lvl;
  generate
    for (gi = 0; gi < astc_pkg::NSRC; gi++)
    begin : g_cmp
      astc_sync3 u_cmp
      (
        .clk  (clk),
        .rst  (rst),
        .din  (cmp_pos[gi]),
        .dout (cmp_lvl[gi]),
        .rise ()
      );
    end
  endgenerate

  logic sel_q, sel_d;    // Previous selected comparator level
  logic cond;            // Edge condition on selected source
  // Line source compares at zero crossing, so level is not used
  assign cond = eff.slope_neg ? (sel_q & ~sel_d) : (~sel_q & sel_d);

  logic [astc_pkg::HO_W-1:0] ho_q, ho_d;    // Time hold-off remaining
  logic [astc_pkg::EV_W-1:0] ev_q, ev_d;    // Events seen since trigger
  logic trig;
  logic ho_clear;

  always_comb
  begin
    sel_d = cmp_lvl[trig_src];
    ho_d  = ho_q;
    ev_d  = ev_q;
    trig  = 1'b0;
    if (holdoff_by_evt)
    begin
      if (cond)
      begin
        if (ev_q >= holdoff_evts)
        begin
          trig = 1'b1;
          ev_d = '0;
        end
        else
          ev_d = ev_q + 1'b1;
      end
    end
    else
    begin
      if (ho_q != '0)
        ho_d = ho_q - 1'b1;
      if (cond && ho_q == '0)
      begin
        trig = 1'b1;
        // Clamp the setting into its legal span
        if (holdoff_time < astc_pkg::HO_W'(astc_pkg::HOLDOFF_MIN_CYC))
          ho_d = astc_pkg::HO_W'(astc_pkg::HOLDOFF_MIN_CYC);
        else if (holdoff_time > astc_pkg::HO_W'(astc_pkg::HOLDOFF_MAX_CYC))
          ho_d = astc_pkg::HO_W'(astc_pkg::HOLDOFF_MAX_CYC);
        else
          ho_d = holdoff_time;
      end
    end
    // Idle: no hold-off pending, so the first qualifying event after arm triggers
    if (ho_clear)
    begin
      ho_d = '0;
      ev_d = holdoff_evts;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_q <= 1'b0;
      ho_q  <= '0;
      ev_q  <= '0;
    end
    else
    begin
      sel_q <= sel_d;
      ho_q  <= ho_d;
      ev_q  <= ev_d;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_FILL = 3'b100
  } astc_st_e;

  astc_st_e                   st_q, st_d;
  logic [astc_pkg::SEG_W-1:0] seg_q, seg_d;    // Current segment
  logic [astc_pkg::DIV_W+3:0] pts_q, pts_d;    // Points left in segment
  logic [31:0]                to_q, to_d;      // Time since last trigger
  logic                       done_q, done_d;
  logic                       to_hit;
  logic                       last_seg;
  logic                       seq;

  assign seq      = (seq_mode != astc_pkg::SEQ_OFF);
  assign last_seg = seq ? (seg_q + 1'b1 >= seg_count) : 1'b1;
  // No timeout under external clock
  assign to_hit   = (trig_mode == astc_pkg::TM_AUTO) && !ext_sel_q && seq
                    && (to_q >= auto_timeout);
  assign trig_out = trig & (st_q == ST_WAIT);
  assign ho_clear = (st_q == ST_IDLE);

  always_comb
  begin
    st_d   = st_q;
    seg_d  = seg_q;
    pts_d  = pts_q;
    to_d   = (st_q == ST_IDLE || trig_out) ? 32'h0 : to_q + 32'h1;
    done_d = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (arm)
        begin
          st_d  = ST_WAIT;
          seg_d = '0;
        end
      end
      ST_WAIT:
      begin
        if (trig_out)
        begin
          st_d  = ST_FILL;
          pts_d = (astc_pkg::DIV_W+4)'(per_div) * (astc_pkg::DIV_W+4)'(astc_pkg::SEG_DIVS);
        end
        else if (to_hit)
        begin
          if (seq_mode == astc_pkg::SEQ_WRAP)
          begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
          end
          else
            seg_d = '0;
        end
      end
      ST_FILL:
      begin
        if (tick)
          pts_d = pts_q - 1'b1;
        if (tick && pts_q <= 1)
        begin
          if (seq_mode == astc_pkg::SEQ_WRAP)
          begin
            st_d  = ST_WAIT;
            seg_d = last_seg ? '0 : seg_q + 1'b1;
          end
          else if (!last_seg)
          begin
            st_d  = ST_WAIT;
            seg_d = seg_q + 1'b1;
          end
          else if (trig_mode == astc_pkg::TM_ONE_SHOT)
          begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
          end
          else
          begin
            st_d  = ST_WAIT;
            seg_d = '0;
          end
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    if (stop_cmd && st_q != ST_IDLE)
    begin
      st_d   = ST_IDLE;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= ST_IDLE;
      seg_q  <= '0;
      pts_q  <= '0;
      to_q   <= 32'h0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      seg_q  <= seg_d;
      pts_q  <= pts_d;
      to_q   <= to_d;
      done_q <= done_d;
    end
  end

  assign seg_idx  = seg_q;
  assign acq_busy = (st_q != ST_IDLE);
  assign done     = done_q;

endmodule

// File: dv/astc_ctrl_asserts.sv
// Purpose: Port-level assertions for acquisition sequence and trigger control
// Assumes: One clock domain, rst asynchronous and active high
// Notes:   Attached to the design by the bind after the module
`timescale 1ns/1ps
module astc_ctrl_asserts
(
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       cfg_wr,
  input wire astc_pkg::astc_src_e        trig_src,
  input wire astc_pkg::astc_trig_cfg_s   cfg_wdata,
  input wire logic                       ext_clk_req,
  input wire logic                       per_div_wr,
  input wire astc_pkg::astc_chuse_e      ch_use,
  input wire logic                       four_ch_unit,
  input wire logic                       smart_type,
  input wire logic                       holdoff_by_evt,
  input wire logic                       stop_cmd,
  input wire logic [astc_pkg::SEG_W-1:0] seg_count,
  input wire logic                       adc_sample_en,
  input wire logic                       ext_clk_active,
  input wire logic [1:0]                 samp_mode,
  input wire logic [1:0]                 pair_mask,
  input wire logic                       stamp_en,
  input wire astc_pkg::astc_trig_cfg_s   cur_cfg,
  input wire logic                       nv_wr,
  input wire logic [astc_pkg::SRC_W-1:0] nv_addr,
  input wire astc_pkg::astc_trig_cfg_s   nv_wdata,
  input wire logic                       trig_out,
  input wire logic [astc_pkg::SEG_W-1:0] seg_idx,
  input wire logic                       acq_busy,
  input wire logic                       done
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_nv_write_follow: assert property (
    cfg_wr |=> nv_wr && nv_addr == $past(trig_src) && nv_wdata == $past(cfg_wdata)) else $error("nv write wrong");
  a_ext_refused: assert property (
    ext_clk_req && trig_src inside {astc_pkg::SRC_EXT, astc_pkg::SRC_EXT10} |=> !ext_clk_active)
    else $error("ext clock taken with ext trigger");
  a_ext_single_shot: assert property (
    ext_clk_active |-> samp_mode == astc_pkg::SAMP_SINGLE && !stamp_en) else $error("ext clock mode wrong");
  a_scale_internal: assert property (
    per_div_wr |=> !ext_clk_active) else $error("scale change kept ext clock");
  a_internal_sampling: assert property (
    !ext_clk_active |-> adc_sample_en) else $error("internal sampling off");
  a_pair_map: assert property (
    pair_mask == ((ch_use == astc_pkg::CHU_2) ? (four_ch_unit ? 2'h3 : 2'h1) : 2'h0)) else $error("pairing wrong");
  a_hf_forced: assert property (
    smart_type || holdoff_by_evt |-> cur_cfg.coupling != astc_pkg::CPL_HF) else $error("hf not overridden");
  a_stop_done: assert property (
    stop_cmd && acq_busy |=> done ##1 !done && !acq_busy) else $error("stop did not end");
  a_seg_bound: assert property (
    acq_busy |-> seg_idx < seg_count) else $error("segment index out of range");
  a_trig_in_acq: assert property (
    trig_out |-> acq_busy) else $error("trigger outside acquisition");
endmodule

bind astc_ctrl astc_ctrl_asserts u_astc_ctrl_asserts (.clk, .rst, .cfg_wr, .trig_src, .cfg_wdata, .ext_clk_req,
  .per_div_wr, .ch_use, .four_ch_unit, .smart_type, .holdoff_by_evt, .stop_cmd, .seg_count, .adc_sample_en,
  .ext_clk_active, .samp_mode, .pair_mask, .stamp_en, .cur_cfg, .nv_wr, .nv_addr, .nv_wdata, .trig_out,
  .seg_idx, .acq_busy, .done);

// File: dv/astc_far_model.sv
// Purpose: Trigger comparators and external sample clock pin
// Assumes: Driven from the bench through tasks
// Notes:   Sample clock pin rests low between bursts
`timescale 1ns/1ps
module astc_far_model
(
  input wire logic                   clk,
  output logic [astc_pkg::NSRC-1:0]  cmp_pos,
  output logic                       rear_sample_clock_input
);
  initial
  begin
    cmp_pos = '0;
    rear_sample_clock_input = 1'b0;
  end
  // One comparator crossing: rise, hold, fall, rest (12 cycles)
  task automatic edge_on(input int s);
    @(posedge clk) cmp_pos[s] <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_pos[s] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // Burst of sample clock pulses, 6 cycles each, well under 100 MHz
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk) rear_sample_clock_input <= 1'b1;
      repeat (3) @(posedge clk);
      rear_sample_clock_input <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// File: dv/tb_astc_ctrl.sv
// Purpose: Self-checking bench for acquisition sequence and trigger control
// Assumes: Per-division count of 1, so a segment fills in 10 cycles
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module tb_astc_ctrl;
  logic                       clk, rst, arm, stop_cmd, per_div_wr, ext_clk_req, four_ch_unit, cfg_wr;
  logic                       smart_type, holdoff_by_evt, adc_sample_en, ext_clk_active, ext_clk_present;
  logic                       stamp_en, nv_wr, trig_out, acq_busy, done, rear_sample_clock_input;
  astc_pkg::astc_tmode_e      trig_mode;
  astc_pkg::astc_seq_e        seq_mode;
  astc_pkg::astc_chuse_e      ch_use;
  astc_pkg::astc_src_e        trig_src;
  astc_pkg::astc_trig_cfg_s   cfg_wdata, cur_cfg, nv_wdata;
  logic [15:0]                seg_count, seg_idx;
  logic [23:0]                per_div;
  logic [1:0]                 samp_mode_req, samp_mode, pair_mask;
  logic [31:0]                auto_timeout;
  logic [32:0]                holdoff_time;
  logic [29:0]                holdoff_evts;
  logic [6:0]                 cmp_pos;
  logic [2:0]                 nv_addr;
  int                         bad_count, samples_checked, trig_cnt;
  localparam astc_pkg::astc_trig_cfg_s WCFG = '{12'h3A5, astc_pkg::CPL_HF, 1'b0}; // Written setting

  astc_ctrl u_astc_ctrl (.clk, .rst, .arm, .stop_cmd, .trig_mode, .seq_mode, .seg_count, .per_div, .per_div_wr,
    .ext_clk_req, .samp_mode_req, .ch_use, .four_ch_unit, .auto_timeout, .trig_src, .cfg_wr, .cfg_wdata,
    .smart_type, .holdoff_by_evt, .holdoff_time, .holdoff_evts, .rear_sample_clock_input, .cmp_pos,
    .adc_sample_en, .ext_clk_active, .ext_clk_present, .samp_mode, .pair_mask, .stamp_en, .cur_cfg, .nv_wr,
    .nv_addr, .nv_wdata, .trig_out, .seg_idx, .acq_busy, .done);
  astc_far_model u_astc_far_model (.clk, .cmp_pos, .rear_sample_clock_input);

  // ----------------------------------------------------------------
  // Clock, trigger counter, helpers
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) if (trig_out === 1'b1) trig_cnt++;
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic start(input astc_pkg::astc_tmode_e tm, input astc_pkg::astc_seq_e sm, input logic [15:0] n);
    @(posedge clk);
    trig_mode <= tm;
    seq_mode <= sm;
    seg_count <= n;
    trig_cnt = 0;
    @(posedge clk) arm <= 1'b1;
    @(posedge clk) arm <= 1'b0;
  endtask
  // Wait for the done pulse under a bound, then expect idle
  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'b1; i++) @(negedge clk);
    chk("done", done, 1);
    cyc(1);
    chk("acq_busy", acq_busy, 0);
  endtask
  task automatic stop_run();
    @(posedge clk) stop_cmd <= 1'b1;
    @(posedge clk) stop_cmd <= 1'b0;
    wait_done(5);
  endtask
  task automatic edges(input int n);
    repeat (n) u_astc_far_model.edge_on(0);
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk, arm, stop_cmd, per_div_wr, ext_clk_req, four_ch_unit, cfg_wr, smart_type, holdoff_by_evt} = '0;
    {samp_mode_req, auto_timeout, holdoff_time, holdoff_evts} = '0;
    trig_mode = astc_pkg::TM_AUTO;
    seq_mode = astc_pkg::SEQ_OFF;
    ch_use = astc_pkg::CHU_1;
    trig_src = astc_pkg::SRC_CH2;
    cfg_wdata = WCFG;
    seg_count = 16'h0002;
    per_div = 24'h000001;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("idle", {done, acq_busy, seg_idx, ext_clk_active}, 0);
    @(posedge clk) cfg_wr <= 1'b1;
    @(posedge clk) cfg_wr <= 1'b0;
    @(negedge clk);
    chk("nv", {nv_wr, nv_addr, nv_wdata}, {1'b1, 3'h1, WCFG});
    chk("cur_cfg", cur_cfg, WCFG);
    @(posedge clk) trig_src <= astc_pkg::SRC_CH1;
    cyc(1);
    chk("cur_cfg other", cur_cfg, astc_pkg::TRIG_CFG_RST);
    @(posedge clk) trig_src <= astc_pkg::SRC_CH2;
    smart_type <= 1'b1;
    cyc(1);
    chk("coupling", cur_cfg.coupling, astc_pkg::CPL_AC);
    @(posedge clk) smart_type <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk) ch_use <= astc_pkg::astc_chuse_e'(i / 2);
      four_ch_unit <= i[0];
      cyc(1);
      chk("pair_mask", pair_mask, (i / 2 == 1) ? (i[0] ? 2'h3 : 2'h1) : 2'h0);
    end
    @(posedge clk) trig_src <= astc_pkg::SRC_EXT;
    ext_clk_req <= 1'b1;
    cyc(2);
    chk("ext refused", ext_clk_active, 0);
    @(posedge clk) trig_src <= astc_pkg::SRC_CH1;
    samp_mode_req <= astc_pkg::SAMP_RIS;
    cyc(2);
    chk("ext mode", {ext_clk_active, samp_mode, stamp_en, ext_clk_present}, {1'b1, 2'h0, 2'b00});
    u_astc_far_model.ext_pulses(45);
    cyc(6);
    chk("present early", ext_clk_present, 0);
    u_astc_far_model.ext_pulses(10);
    cyc(6);
    chk("present", ext_clk_present, 1);
    @(posedge clk) per_div_wr <= 1'b1;
    @(posedge clk) per_div_wr <= 1'b0;
    @(negedge clk);
    chk("scale change", ext_clk_active, 0);
    cyc(1);
    chk("scale held", ext_clk_active, 0);
    @(posedge clk) ext_clk_req <= 1'b0;
    start(astc_pkg::TM_ONE_SHOT, astc_pkg::SEQ_ON, 16'h0002);
    cyc(30);
    chk("waiting", {acq_busy, done}, 2'b10);
    edges(1);
    cyc(20);
    chk("seg_idx", seg_idx, 1);
    edges(1);
    wait_done(40);
    chk("triggers", trig_cnt, 2);
    start(astc_pkg::TM_REARM, astc_pkg::SEQ_ON, 16'h0002);
    edges(3);
    cyc(20);
    chk("rearm idx", {acq_busy, seg_idx}, 17'h10001);
    stop_run();
    @(posedge clk) holdoff_by_evt <= 1'b1;
    holdoff_evts <= 30'h2;
    start(astc_pkg::TM_REARM, astc_pkg::SEQ_WRAP, 16'h0004);
    edges(7);
    chk("event holdoff", trig_cnt, 3);
    stop_run();
    @(posedge clk) holdoff_by_evt <= 1'b0;
    holdoff_time <= 33'h32;
    start(astc_pkg::TM_REARM, astc_pkg::SEQ_WRAP, 16'h0004);
    edges(7);
    chk("time holdoff", trig_cnt, 2);
    stop_run();
    @(posedge clk) holdoff_time <= '0;
    auto_timeout <= 32'h64;
    start(astc_pkg::TM_AUTO, astc_pkg::SEQ_ON, 16'h0004);
    edges(1);
    cyc(20);
    chk("auto idx", seg_idx, 1);
    cyc(150);
    chk("auto restart", {acq_busy, seg_idx}, 17'h10000);
    stop_run();
    start(astc_pkg::TM_AUTO, astc_pkg::SEQ_WRAP, 16'h0004);
    edges(1);
    wait_done(300);
    print_verdict();
  end
endmodule
